/* File: include/uil_regs.vh */
// constants for the interrupt identify and line format block
// assumes word-aligned apb byte addresses and a 16x baud tick
`ifndef UIL_REGS_VH
`define UIL_REGS_VH

// ****************************************
// register byte addresses
// ****************************************
`define UIL_OFF_DATA 8'h00
`define UIL_OFF_IER 8'h04
`define UIL_OFF_IIR 8'h08
`define UIL_OFF_LCR 8'h0c
`define UIL_OFF_LSR 8'h14
`define UIL_OFF_MSR 8'h18

// ****************************************
// field positions
// ****************************************
`define UIL_LCR_STB 2
`define UIL_LCR_PEN 3
`define UIL_LCR_EVEN 4
`define UIL_LCR_STICK 5
`define UIL_LCR_BRK 6
`define UIL_LCR_DIVISOR_ACCESS_SELECT 7
`define UIL_IER_RDA 0
`define UIL_IER_THR 1
`define UIL_IER_RLS 2
`define UIL_IER_MS 3
`define UIL_FCR_EN 0
`define UIL_FCR_RXCLR 1
`define UIL_FCR_TXCLR 2

// ****************************************
// identification codes, bits 3:0
// ****************************************
`define UIL_ID_NONE 4'h1
`define UIL_ID_RLS 4'h6
`define UIL_ID_RDA 4'h4
`define UIL_ID_CTO 4'hc
`define UIL_ID_THR 4'h2
`define UIL_ID_MS 4'h0

// ****************************************
// reset values
// ****************************************
`define UIL_RST_LCR 8'h00
`define UIL_RST_IER 4'h0
`define UIL_RST_DIV 16'h0001
`define UIL_RST_TRIG 2'b00
`define UIL_RST_SYNC 5'h10

// ****************************************
// timing in 16x ticks, frame sizes and fifo trigger levels
// ****************************************
`define UIL_SUB_HALF 5'h07
`define UIL_SUB_LAST 5'h0f
`define UIL_STOP15_LAST 5'h17
`define UIL_STOP2_LAST 5'h1f
`define UIL_LAST_BASE 3'h4
`define UIL_FRAME_BASE 4'h7
`define UIL_TO_PAD 6'h00
`define UIL_TRIG1 8'h01
`define UIL_TRIG4 8'h04
`define UIL_TRIG8 8'h08
`define UIL_TRIG14 8'h0e

`endif

/* File: rtl/uil_core.v */
// serial element core: apb registers, line format, tx/rx, interrupt id
// assumes one clock, apb master on the same clock, raw async pins
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`include "uil_regs.vh"

module uil_core #(
  parameter AW = 4
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire serialInLine,
  input wire ctsIn,
  input wire dsrIn,
  input wire riIn,
  input wire dcdIn,
  output wire serialOutputLine,
  output wire interruptOut
);

  localparam [3:0] SEL_DATA = 4'h0, SEL_IER = 4'h1, SEL_IIR = 4'h2, SEL_LCR = 4'h3;
  localparam [3:0] SEL_LSR = 4'h4, SEL_MSR = 4'h5, SEL_DLL = 4'h6, SEL_DLM = 4'h7;
  localparam [3:0] SEL_NONE = 4'h8;
  localparam [4:0] TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10;
  localparam [4:0] RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10;
  localparam [AW:0] FULL_CNT = {1'b1, {AW{1'b0}}};

  // ****************************************
  // functions
  // ****************************************
  // divisor access bit swaps the two low offsets
  function [3:0] regDecode(input [7:0] a, input divisor_access_select);
    begin
      if (a == `UIL_OFF_DATA) regDecode = divisor_access_select ? SEL_DLL : SEL_DATA;
      else if (a == `UIL_OFF_IER) regDecode = divisor_access_select ? SEL_DLM : SEL_IER;
      else if (a == `UIL_OFF_IIR) regDecode = SEL_IIR;
      else if (a == `UIL_OFF_LCR) regDecode = SEL_LCR;
      else if (a == `UIL_OFF_LSR) regDecode = SEL_LSR;
      else if (a == `UIL_OFF_MSR) regDecode = SEL_MSR;
      else regDecode = SEL_NONE;
    end
  endfunction

  // keeps only the programmed number of data bits
  function [7:0] charMask(input [1:0] len);
    charMask = 8'hff >> (2'h3 - len);
  endfunction

  // parity bit for a character under a format byte
  function parBit(input [7:0] d, input [7:0] f);
    begin
      if (f[`UIL_LCR_STICK]) parBit = ~f[`UIL_LCR_EVEN];
      else if (f[`UIL_LCR_EVEN]) parBit = ^(d & charMask(f[1:0]));
      else parBit = ~^(d & charMask(f[1:0]));
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  reg [4:0] syncA_r, syncB_r;
  reg [3:0] msPrev_r, delta_r;
  reg [31:0] prdata_r;
  reg pslverr_r;
  reg [7:0] lcr_r, rdMux;
  reg [3:0] ier_r, idCode;
  reg [15:0] div_r, baudCnt_r;
  reg fifoEn_r;
  reg [1:0] trig_r;
  reg [4:0] txState_r, txSub_r, rxState_r, rxSub_r;
  reg [7:0] thr_r, txShift_r, rxShift_r;
  reg thrFull_r, txPar_r, txLine_r, serialOut_r;
  reg [2:0] txBit_r, rxBit_r;
  reg rxArm_r, rxPar_r, rxFe_r, rxDone_r;
  reg [7:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wrPtr_r, rdPtr_r;
  reg [AW:0] cnt_r;
  reg [3:0] lsErr_r;
  reg threPrev_r, thrIntr_r, toFlag_r, irq_r;
  reg [9:0] toCnt_r;
  reg [7:0] trigLevel;

  wire setupPh = psel & ~penable;
  wire accessPh = psel & penable;
  wire [3:0] curSel = regDecode(paddr, lcr_r[`UIL_LCR_DIVISOR_ACCESS_SELECT]);
  wire wrEv = accessPh & pwrite;
  wire rdEv = accessPh & ~pwrite;
  wire wrData = wrEv & (curSel == SEL_DATA);
  wire rdData = rdEv & (curSel == SEL_DATA);
  wire wrFcr = wrEv & (curSel == SEL_IIR);
  wire rdIir = rdEv & (curSel == SEL_IIR);
  wire rdLsr = rdEv & (curSel == SEL_LSR);
  wire rdMsr = rdEv & (curSel == SEL_MSR);
  wire rxIn = syncB_r[4];
  wire [3:0] modemNow = syncB_r[3:0];
  wire tick16 = (baudCnt_r == 16'h0000);
  wire pen = lcr_r[`UIL_LCR_PEN];
  wire [2:0] lastIdx = `UIL_LAST_BASE + {1'b0, lcr_r[1:0]};
  wire [4:0] stopLast = ~lcr_r[`UIL_LCR_STB] ? `UIL_SUB_LAST :
    (lcr_r[1:0] == 2'b00) ? `UIL_STOP15_LAST : `UIL_STOP2_LAST;
  wire [4:0] txSubLast = (txState_r == TX_STOP) ? stopLast : `UIL_SUB_LAST;
  wire txBitEnd = tick16 & (txSub_r == txSubLast);
  wire rxBitEnd = tick16 & (rxSub_r == `UIL_SUB_LAST);
  wire rxHalf = tick16 & (rxSub_r == `UIL_SUB_HALF);
  wire tx_holding_empty = ~thrFull_r;
  wire temt = tx_holding_empty & (txState_r == TX_IDLE);
  wire full = fifoEn_r ? cnt_r[AW] : (|cnt_r);
  wire push = rxDone_r & ~full;
  wire pop = rdData & (|cnt_r);
  wire fifoClr = wrFcr & ((pwdata[`UIL_FCR_EN] ^ fifoEn_r) | (pwdata[`UIL_FCR_EN] & pwdata[`UIL_FCR_RXCLR]));
  wire txClr = wrFcr & ((pwdata[`UIL_FCR_EN] ^ fifoEn_r) | (pwdata[`UIL_FCR_EN] & pwdata[`UIL_FCR_TXCLR]));
  wire perr = pen & (rxPar_r != parBit(rxShift_r, lcr_r));
  wire brk = (rxShift_r == 8'h00) & ~(pen & rxPar_r) & rxFe_r;
  wire [7:0] cntWide = {{(7-AW){1'b0}}, cnt_r};
  wire [3:0] charBits = `UIL_FRAME_BASE + {2'b00, lcr_r[1:0]} + {3'b000, pen} + {3'b000, lcr_r[`UIL_LCR_STB]};
  wire [9:0] toLimit = {charBits, `UIL_TO_PAD};
  wire lsIntr = ier_r[`UIL_IER_RLS] & (|lsErr_r);
  wire rdaIntr = ier_r[`UIL_IER_RDA] & (fifoEn_r ? (cntWide >= trigLevel) : (|cnt_r));
  wire toIntr = ier_r[`UIL_IER_RDA] & toFlag_r;
  wire thIntr = ier_r[`UIL_IER_THR] & thrIntr_r;
  wire msIntr = ier_r[`UIL_IER_MS] & (|delta_r);
  wire [7:0] iirVal = {fifoEn_r, fifoEn_r, 2'b00, idCode};

  // ****************************************
  // pin synchronisers
  // ****************************************
  // second stage only is read, edges compare stage two history
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= `UIL_RST_SYNC;
      syncB_r <= `UIL_RST_SYNC;
    end else begin
      syncA_r <= {serialInLine, dcdIn, riIn, dsrIn, ctsIn};
      syncB_r <= syncA_r;
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  // read value chosen by address
  always @* begin
    if (curSel == SEL_DATA) rdMux = (|cnt_r) ? mem[rdPtr_r] : 8'h00;
    else if (curSel == SEL_IER) rdMux = {4'h0, ier_r};
    else if (curSel == SEL_IIR) rdMux = iirVal;
    else if (curSel == SEL_LCR) rdMux = lcr_r;
    else if (curSel == SEL_LSR) rdMux = {fifoEn_r & (|lsErr_r[3:1]), temt, tx_holding_empty, lsErr_r, |cnt_r};
    else if (curSel == SEL_MSR) rdMux = {modemNow, delta_r};
    else if (curSel == SEL_DLL) rdMux = div_r[7:0];
    else if (curSel == SEL_DLM) rdMux = div_r[15:8];
    else rdMux = 8'h00;
  end

  // captured in setup so data is stable for the whole access phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (setupPh) begin
      prdata_r <= {24'h000000, rdMux};
      pslverr_r <= (curSel == SEL_NONE);
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign pready = 1'b1;

  // ****************************************
  // configuration registers
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lcr_r <= `UIL_RST_LCR;
      ier_r <= `UIL_RST_IER;
      div_r <= `UIL_RST_DIV;
      fifoEn_r <= 1'b0;
      trig_r <= `UIL_RST_TRIG;
    end else if (wrEv) begin
      if (curSel == SEL_LCR) lcr_r <= pwdata[7:0];
      else if (curSel == SEL_IER) ier_r <= pwdata[3:0];
      else if (curSel == SEL_DLL) div_r[7:0] <= pwdata[7:0];
      else if (curSel == SEL_DLM) div_r[15:8] <= pwdata[7:0];
      else if (curSel == SEL_IIR) begin
        fifoEn_r <= pwdata[`UIL_FCR_EN];
        // other fcr bits only land with the enable bit set
        if (pwdata[`UIL_FCR_EN]) trig_r <= pwdata[7:6];
      end
    end
  end

  // trigger level lookup
  always @* begin
    case (trig_r)
      2'b00: trigLevel = `UIL_TRIG1;
      2'b01: trigLevel = `UIL_TRIG4;
      2'b10: trigLevel = `UIL_TRIG8;
      default: trigLevel = `UIL_TRIG14;
    endcase
  end

  // ****************************************
  // baud tick, divisor zero behaves as 65536
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) baudCnt_r <= 16'h0000;
    else baudCnt_r <= tick16 ? div_r - 16'h0001 : baudCnt_r - 16'h0001;
  end

  // ****************************************
  // transmitter
  // ****************************************
  // a single holding register stands in for the tx fifo as well
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState_r <= TX_IDLE;
      txSub_r <= 5'h00;
      txBit_r <= 3'h0;
      txShift_r <= 8'h00;
      txPar_r <= 1'b0;
      txLine_r <= 1'b1;
      thr_r <= 8'h00;
      thrFull_r <= 1'b0;
    end else begin
      if (tick16 && txState_r != TX_IDLE) txSub_r <= txBitEnd ? 5'h00 : txSub_r + 5'h01;
      case (txState_r)
        TX_IDLE: begin
          txLine_r <= 1'b1;
          txSub_r <= 5'h00;
          if (thrFull_r) begin
            txShift_r <= thr_r;
            txPar_r <= parBit(thr_r, lcr_r);
            thrFull_r <= 1'b0;
            txLine_r <= 1'b0;
            txState_r <= TX_START;
          end
        end
        TX_START: if (txBitEnd) begin
          txState_r <= TX_DATA;
          txBit_r <= 3'h0;
          txLine_r <= txShift_r[0];
        end
        TX_DATA: if (txBitEnd) begin
          txShift_r <= txShift_r >> 1;
          txBit_r <= txBit_r + 3'h1;
          if (txBit_r == lastIdx) begin
            txState_r <= pen ? TX_PAR : TX_STOP;
            txLine_r <= pen ? txPar_r : 1'b1;
          end else txLine_r <= txShift_r[1];
        end
        TX_PAR: if (txBitEnd) begin
          txState_r <= TX_STOP;
          txLine_r <= 1'b1;
        end
        TX_STOP: if (txBitEnd) txState_r <= TX_IDLE;
        default: txState_r <= TX_IDLE;
      endcase
      // later assignment lets a new write beat the load or a clear
      if (txClr) thrFull_r <= 1'b0;
      if (wrData) begin
        thr_r <= pwdata[7:0];
        thrFull_r <= 1'b1;
      end
    end
  end

  // break gates only the pin, the shifter keeps running
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) serialOut_r <= 1'b1;
    else serialOut_r <= txLine_r & ~lcr_r[`UIL_LCR_BRK];
  end

  assign serialOutputLine = serialOut_r;

  // ****************************************
  // receiver
  // ****************************************
  // arm needs the line high first, so a held break gives one character
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_r <= RX_IDLE;
      rxSub_r <= 5'h00;
      rxBit_r <= 3'h0;
      rxShift_r <= 8'h00;
      rxPar_r <= 1'b0;
      rxFe_r <= 1'b0;
      rxArm_r <= 1'b0;
      rxDone_r <= 1'b0;
    end else begin
      rxDone_r <= 1'b0;
      if (rxIn) rxArm_r <= 1'b1;
      // wraps at each bit end, else the next sample drifts a whole bit late
      if (tick16 && rxState_r != RX_IDLE) rxSub_r <= rxBitEnd ? 5'h00 : rxSub_r + 5'h01;
      case (rxState_r)
        RX_IDLE: begin
          rxSub_r <= 5'h00;
          if (!rxIn && rxArm_r) rxState_r <= RX_START;
        end
        RX_START: if (rxHalf) begin
          rxSub_r <= 5'h00;
          rxBit_r <= 3'h0;
          rxShift_r <= 8'h00;
          rxState_r <= rxIn ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rxBitEnd) begin
          rxShift_r[rxBit_r] <= rxIn;
          rxBit_r <= rxBit_r + 3'h1;
          if (rxBit_r == lastIdx) rxState_r <= pen ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rxBitEnd) begin
          rxPar_r <= rxIn;
          rxState_r <= RX_STOP;
        end
        RX_STOP: if (rxBitEnd) begin
          rxFe_r <= ~rxIn;
          rxDone_r <= 1'b1;
          rxArm_r <= 1'b0;
          rxState_r <= RX_IDLE;
        end
        default: rxState_r <= RX_IDLE;
      endcase
    end
  end

  // receive store; capacity one in character mode, where an overrun overwrites; fifo mode drops it
  always @(posedge clk) begin
    if (push) mem[wrPtr_r] <= rxShift_r;
    else if (rxDone_r && !fifoEn_r) mem[rdPtr_r] <= rxShift_r;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (fifoClr) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
      if (pop) rdPtr_r <= rdPtr_r + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop) cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
      else if (pop && !push) cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // sticky event flags, set beats clear
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lsErr_r <= 4'h0;
      msPrev_r <= 4'h0;
      delta_r <= 4'h0;
      threPrev_r <= 1'b0;
      thrIntr_r <= 1'b0;
      toCnt_r <= 10'h000;
      toFlag_r <= 1'b0;
    end else begin
      // overrun, parity, framing, break
      lsErr_r <= (lsErr_r & ~{4{rdLsr}}) | ({4{rxDone_r}} & {brk, rxFe_r, perr, full});
      msPrev_r <= modemNow;
      delta_r <= (delta_r & ~{4{rdMsr}}) | (modemNow ^ msPrev_r);
      threPrev_r <= tx_holding_empty;
      // empty edge, or any ier write with the thr enable bit set while already empty
      thrIntr_r <= (thrIntr_r & ~(wrData | (rdIir & (idCode == `UIL_ID_THR)))) |
        (tx_holding_empty & ~threPrev_r) | (tx_holding_empty & wrEv & (curSel == SEL_IER) & pwdata[`UIL_IER_THR]);
      // any push or pop restarts the idle timer
      if (push || pop || !fifoEn_r || cnt_r == FULL_CNT - FULL_CNT) toCnt_r <= 10'h000;
      else if (tick16 && toCnt_r != toLimit) toCnt_r <= toCnt_r + 10'h001;
      if (fifoEn_r && (|cnt_r) && !push && !pop && toCnt_r == toLimit) toFlag_r <= 1'b1;
      else if (pop || !(|cnt_r) || fifoClr) toFlag_r <= 1'b0;
    end
  end

  // ****************************************
  // identification and interrupt output
  // ****************************************
  // fixed priority, line status first and modem status last
  always @* begin
    if (lsIntr) idCode = `UIL_ID_RLS;
    else if (rdaIntr) idCode = `UIL_ID_RDA;
    else if (toIntr) idCode = `UIL_ID_CTO;
    else if (thIntr) idCode = `UIL_ID_THR;
    else if (msIntr) idCode = `UIL_ID_MS;
    else idCode = `UIL_ID_NONE;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) irq_r <= 1'b0;
    else irq_r <= ~idCode[0];
  end

  assign interruptOut = irq_r;

endmodule

/* File: bench/uil_core_chk.sv */
// checker on the serial core's apb and pin behaviour
// assumes format and enable change only through apb writes
`timescale 1ns/1ps
module uil_core_chk (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire serialOutputLine,
  input wire interruptOut
);
  // *******
  // shadows
  // *******
  reg [7:0] lcrShadow_r;
  reg [3:0] ierShadow_r;
  wire acc = psel && penable;
  wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18};
  // mirror writes at the access edge, as the core does
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lcrShadow_r <= 8'h00;
      ierShadow_r <= 4'h0;
    end else if (acc && pwrite) begin
      if (paddr == 8'h0c) lcrShadow_r <= pwdata[7:0];
      if (paddr == 8'h04 && !lcrShadow_r[7]) ierShadow_r <= pwdata[3:0];
    end
  end
  // *******
  // properties
  // *******
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence idRead;
    acc && !pwrite && paddr == 8'h08;
  endsequence
  // break must hold a few cycles, the pin is registered
  sequence brkHeld;
    lcrShadow_r[6] [*3];
  endsequence
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  a_id_zero_bits: assert property (idRead |-> prdata[5:4] == 2'b00 && prdata[31:8] == 24'h0)
    else $error("identity unused bits set");
  a_id_pend_irq: assert property (idRead |-> interruptOut == !prdata[0])
    else $error("interrupt output disagrees with identity");
  a_id_code_legal: assert property (idRead |-> prdata[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hc})
    else $error("illegal identity code");
  a_id_fifo_pair: assert property (idRead |-> prdata[7] == prdata[6] && (!prdata[3] || prdata[7]))
    else $error("fifo identity bits inconsistent");
  a_format_readback: assert property (acc && !pwrite && paddr == 8'h0c |-> prdata[7:0] == lcrShadow_r)
    else $error("format register readback differs");
  a_break_low: assert property (brkHeld |-> !serialOutputLine)
    else $error("output not held low in break");
  a_masked_quiet: assert property ((ierShadow_r == 4'h0) [*3] |-> !interruptOut)
    else $error("interrupt with all sources disabled");
endmodule
bind uil_core uil_core_chk i_uil_core_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .serialOutputLine(serialOutputLine), .interruptOut(interruptOut)
);

/* File: bench/uil_serial_peer.sv */
// far-end serial peer: drives the rx pin, samples the tx pin
// assumes divisor 1, so a bit lasts 16 clocks
`timescale 1ns/1ps
module uil_serial_peer (
  input wire clk,
  input wire serialOutputLine,
  output logic serialInLine
);
  // *******
  // driver and sampler
  // *******
  // line rests at mark level between frames
  initial serialInLine = 1'b1;
  // whole bit string in one call, so frames run back to back
  task automatic send(input logic [23:0] b, input int nb);
    for (int i = 0; i < nb; i++) begin
      serialInLine <= b[i];
      repeat (16) @(posedge clk);
    end
  endtask
  // bit centres, then start-to-start time of the next frame
  task automatic grab(input int nb, output logic [11:0] b, output int per);
    b = '0;
    @(negedge serialOutputLine);
    for (int i = 0; i < nb; i++) begin
      repeat (i == 0 ? 8 : 16) @(posedge clk);
      b[i] = serialOutputLine;
    end
    per = 8 + 16 * (nb - 1);
    while (serialOutputLine !== 1'b0) begin
      @(posedge clk);
      per++;
    end
  endtask
endmodule

/* File: bench/uil_irq_identify_line_format_test.sv */
// bench for the interrupt identify and line format core
// assumes divisor left at reset value 1 and a serial peer on the pins
`timescale 1ns/1ps
module uil_irq_identify_line_format_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ctsIn = 1'b0;
  logic dsrIn = 1'b0;
  logic riIn = 1'b0;
  logic dcdIn = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, serialInLine, serialOutputLine, interruptOut;
  int errors = 0;
  int numChecks = 0;
  logic lastErr;
  logic [31:0] rv;
  // *******
  // instances
  // *******
  uil_core #(.AW(4)) i_uil_core (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serialInLine(serialInLine), .ctsIn(ctsIn), .dsrIn(dsrIn), .riIn(riIn), .dcdIn(dcdIn),
    .serialOutputLine(serialOutputLine), .interruptOut(interruptOut)
  );
  uil_serial_peer i_uil_serial_peer (
    .clk(clk), .serialOutputLine(serialOutputLine), .serialInLine(serialInLine)
  );
  // 40 mhz clock
  always #12.5 clk = ~clk;
  // *******
  // shared tasks
  // *******
  task automatic report_and_stop;
    if (errors == 0 && numChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; the answer is taken only when pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, rv, exp);
  endtask
  // *******
  // scenarios
  // *******
  task automatic t_regs;
    rdc(8'h08, 32'h01, "ident");
    rdc(8'h0c, 32'h00, "format");
    apb(1'b0, 8'h1c, 8'h00);
    chk("slverr", lastErr, 1'b1);
    apb(1'b1, 8'h0c, 8'h83);
    rdc(8'h00, 32'h01, "divlow");
    rdc(8'h04, 32'h00, "divhigh");
    apb(1'b1, 8'h0c, 8'h5a);
    rdc(8'h0c, 32'h5a, "format");
    chk("brk", serialOutputLine, 1'b0);
  endtask
  // each format sends two back-to-back frames
  task automatic t_tx;
    logic [7:0] fmts [7] = '{8'h03, 8'h04, 8'h07, 8'h0b, 8'h1a, 8'h2b, 8'h3b};
    logic [11:0] b;
    logic [7:0] lc, dm;
    logic par;
    int n, nb, per, pe;
    for (int k = 0; k < 7; k++) begin
      lc = fmts[k];
      n = 5 + lc[1:0];
      dm = 8'h96 & 8'((1 << n) - 1);
      nb = 2 + n + lc[3];
      pe = 16 * (nb - 1) + (!lc[2] ? 16 : (n == 5 ? 24 : 32));
      par = lc[5] ? !lc[4] : (lc[4] ? ^dm : ~^dm);
      apb(1'b1, 8'h0c, lc);
      fork
        i_uil_serial_peer.grab(nb, b, per);
        begin
          apb(1'b1, 8'h00, 8'h96);
          repeat (4) @(posedge clk);
          apb(1'b1, 8'h00, 8'h96);
        end
      join
      chk("data", 32'(b >> 1) & 32'((1 << n) - 1), 32'(dm));
      if (lc[3]) chk("parity", b[n + 1], par);
      chk("stop", b[nb - 1], 1'b1);
      chk("period", per >= pe && per <= pe + 3, 1'b1);
      repeat (300) @(posedge clk);
    end
  endtask
  // two frames with one stop bit while two are programmed
  task automatic t_rx_fifo;
    apb(1'b1, 8'h0c, 8'h07);
    apb(1'b1, 8'h04, 8'h01);
    apb(1'b1, 8'h08, 8'h41);
    i_uil_serial_peer.send({4'hf, 1'b1, 8'h3c, 1'b0, 1'b1, 8'hc5, 1'b0}, 24);
    repeat (40) @(posedge clk);
    rdc(8'h08, 32'hc1, "ident");
    rdc(8'h14, 32'h61, "status");
    repeat (1200) @(posedge clk);
    rdc(8'h08, 32'hcc, "ident");
    chk("irq", interruptOut, 1'b1);
    rdc(8'h00, 32'hc5, "rxdata");
    rdc(8'h08, 32'hc1, "ident");
    rdc(8'h00, 32'h3c, "rxdata");
    apb(1'b1, 8'h08, 8'h00);
    rdc(8'h08, 32'h01, "ident");
  endtask
  // wrong even parity on data 01
  task automatic t_rx_err;
    apb(1'b1, 8'h0c, 8'h1b);
    apb(1'b1, 8'h04, 8'h05);
    i_uil_serial_peer.send({14'h3fff, 1'b0, 8'h01, 1'b0}, 24);
    repeat (40) @(posedge clk);
    rdc(8'h08, 32'h06, "ident");
    rdc(8'h14, 32'h65, "status");
    rdc(8'h08, 32'h04, "ident");
    rdc(8'h00, 32'h01, "rxdata");
    rdc(8'h08, 32'h01, "ident");
  endtask
  task automatic t_prio;
    apb(1'b1, 8'h04, 8'h0a);
    ctsIn <= 1'b1;
    dsrIn <= 1'b1;
    riIn <= 1'b1;
    dcdIn <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(8'h08, 32'h02, "ident");
    chk("irq", interruptOut, 1'b1);
    rdc(8'h08, 32'h00, "ident");
    rdc(8'h18, 32'hff, "modem");
    rdc(8'h08, 32'h01, "ident");
    chk("irq", interruptOut, 1'b0);
  endtask
  // *******
  // main sequence and watchdog
  // *******
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_tx();
    t_rx_fifo();
    t_rx_err();
    t_prio();
    report_and_stop();
  end
  // about three and a half times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule
